// file: core/sdli_consts.svh
`ifndef SDLI_CONSTS_SVH
`define SDLI_CONSTS_SVH

// converter code width and clear codes
`define SDLI_CODE_W 16
`define SDLI_CODE_MSB 15
`define SDLI_MID_SCALE 16'h8000
`define SDLI_MIN_SCALE 16'h0000
// contents after srst; the part itself powers up undefined
`define SDLI_RESET_CODE 16'h0000
// synchronised pin vector layout
`define SDLI_PIN_W 6
`define SDLI_PIN_SEL 0
`define SDLI_PIN_SCK 1
`define SDLI_PIN_SDI 2
`define SDLI_PIN_LD 3
`define SDLI_PIN_CLR 4
`define SDLI_PIN_LVL 5
// pin idle levels after srst: select high, clock high, load low, clear inactive
// load must idle low here, or the edge detector sees a false load after srst
`define SDLI_PIN_IDLE 6'h13

`endif

// file: core/sdli_pkg.sv
`include "sdli_consts.svh"

package sdli_pkg;
  // one converter code word
  typedef logic [`SDLI_CODE_MSB:0] sdli_code_t;
  // synchronised pin vector
  typedef logic [`SDLI_PIN_W-1:0] sdli_pins_t;
endpackage

// file: core/sdli_serial_dac_load.sv
`include "sdli_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sdli_serial_dac_load (
  input wire logic mclk, // block clock, 40 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic select_n, // pin: select, active low
  input wire logic shift_clock, // pin: serial shift clock
  input wire logic serial_in, // pin: serial data in
  input wire logic load_strobe, // pin: load, rising edge acts
  input wire logic async_clear_n, // pin: clear, active low level
  input wire logic clear_level_select, // pin: 1 mid-scale, 0 min-scale
  output logic serial_out, // pin: serial data out
  output logic serial_out_oe, // high while serial_out is driven
  output sdli_pkg::sdli_code_t input_code, // input (shift) register
  output sdli_pkg::sdli_code_t dac_code // converter register
);

  sdli_pkg::sdli_pins_t pins_raw;
  sdli_pkg::sdli_pins_t meta_r;
  sdli_pkg::sdli_pins_t sync_r;
  logic sel_s, sck_s, sdi_s, ld_s, clr_n_s, lvl_s;
  logic sel_d_r, sck_d_r, ld_d_r;
  logic sck_rise, sel_rise, ld_rise, shift_en;
  sdli_pkg::sdli_code_t shreg_r;
  sdli_pkg::sdli_code_t dac_r;
  sdli_pkg::sdli_code_t clear_code;
  logic oe_r;

  assign pins_raw = {clear_level_select, async_clear_n, load_strobe,
                     serial_in, shift_clock, select_n};

  // two-flop synchroniser; only sync_r is read by logic
  // all six pins share the same stages, so data stays aligned with its clock
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_r <= `SDLI_PIN_IDLE;
      sync_r <= `SDLI_PIN_IDLE;
    end
    else
    begin
      meta_r <= pins_raw;
      sync_r <= meta_r;
    end
  end

  assign sel_s = sync_r[`SDLI_PIN_SEL];
  assign sck_s = sync_r[`SDLI_PIN_SCK];
  assign sdi_s = sync_r[`SDLI_PIN_SDI];
  assign ld_s = sync_r[`SDLI_PIN_LD];
  assign clr_n_s = sync_r[`SDLI_PIN_CLR];
  assign lvl_s = sync_r[`SDLI_PIN_LVL];

  // delayed copies for edge detection
  // reset values match the pin idle levels so no false edge follows srst
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sel_d_r <= 1'b1;
      sck_d_r <= 1'b1;
      ld_d_r <= 1'b0;
    end
    else
    begin
      sel_d_r <= sel_s;
      sck_d_r <= sck_s;
      ld_d_r <= ld_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;
  assign sel_rise = sel_s & ~sel_d_r;
  assign ld_rise = ld_s & ~ld_d_r;

  // shift on a rising clock while selected; a select rising with the clock low
  // still clocks the register once, as the pin logic does, so it is modelled
  // limitation: each shift_clock phase must span at least three mclk periods
  assign shift_en = (~sel_s & sck_rise)
                    | (sel_rise & ~sck_s);

  // clear code chosen live from the level select
  // the clear is sampled through the synchroniser, so it acts three mclk late
  assign clear_code = lvl_s ? `SDLI_MID_SCALE : `SDLI_MIN_SCALE;

  // shift (input) register; clear overrides all serial activity
  // input and shift register are one register here, which saves sixteen flops
  always_ff @(posedge mclk)
  begin
    if (srst)
      shreg_r <= `SDLI_RESET_CODE;
    else if (!clr_n_s)
      shreg_r <= clear_code;
    else if (shift_en)
      shreg_r <= {shreg_r[`SDLI_CODE_MSB-1:0], sdi_s};
    else
      shreg_r <= shreg_r;
  end

  // converter register: copy on load edge, clear wins
  always_ff @(posedge mclk)
  begin
    if (srst)
      dac_r <= `SDLI_RESET_CODE;
    else if (!clr_n_s)
      dac_r <= clear_code;
    else if (ld_rise)
      dac_r <= shreg_r;
  end

  // serial_out driver enable follows select
  // it lags the select pin by three mclk; the pad floats for that long
  always_ff @(posedge mclk)
  begin
    if (srst)
      oe_r <= 1'b0;
    else
      oe_r <= ~sel_s;
  end

  assign serial_out = shreg_r[`SDLI_CODE_MSB];
  assign serial_out_oe = oe_r;
  assign input_code = shreg_r;
  assign dac_code = dac_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence s_idle;
    clr_n_s && sel_s && sel_d_r;
  endsequence

  sequence s_sel_shift;
    clr_n_s && !sel_s && sck_rise;
  endsequence

  sequence s_bad_release;
    clr_n_s && sel_rise && !sck_s;
  endsequence

  // clear held over two edges with the level select moving on the second
  sequence s_clear_held;
    !clr_n_s ##1 (!clr_n_s && $changed(lvl_s));
  endsequence

  // a load edge with nothing new shifted in since the last one
  sequence s_same_load;
    clr_n_s && ld_rise && (dac_r == shreg_r);
  endsequence

  a_idle_hold: assert property (s_idle |=> shreg_r == $past(shreg_r))
    else $error("shift register moved while deselected");

  a_oe_follow: assert property (!sel_s |=> serial_out_oe)
    else $error("serial_out not driven while selected");

  a_oe_release: assert property (sel_s |=> !serial_out_oe)
    else $error("serial_out driven while deselected");

  a_shift_bit: assert property (s_sel_shift |=>
      shreg_r == {$past(shreg_r[`SDLI_CODE_MSB-1:0]), $past(sdi_s)})
    else $error("serial bit not captured on rising shift clock");

  a_msb_first: assert property (s_sel_shift ##1 (!shift_en && clr_n_s) |=>
      serial_out == $past(shreg_r[`SDLI_CODE_MSB-1], 2))
    else $error("serial_out not carrying next older bit");

  a_extra_shift: assert property (s_bad_release |=>
      shreg_r == {$past(shreg_r[`SDLI_CODE_MSB-1:0]), $past(sdi_s)})
    else $error("missing extra shift on select release with clock low");

  a_load_copy: assert property (clr_n_s && ld_rise |=> dac_r == $past(shreg_r))
    else $error("converter register not loaded on load edge");

  a_load_hold: assert property (clr_n_s && !ld_rise |=> dac_r == $past(dac_r))
    else $error("converter register changed without load edge");

  a_clear_code: assert property (!clr_n_s |=>
      dac_r == ($past(lvl_s) ? `SDLI_MID_SCALE : `SDLI_MIN_SCALE)
      && shreg_r == dac_r)
    else $error("clear did not force selected code");

  a_clear_switch: assert property (s_clear_held |=> $changed(dac_r))
    else $error("level select change ignored during clear");

  a_reload_same: assert property (s_same_load |=> $stable(dac_r))
    else $error("repeated load changed converter register");

  a_byte_freeze: assert property (clr_n_s && sel_s && !sel_rise |=> $stable(serial_out))
    else $error("serial_out moved while deselected");

  a_clear_wins: assert property (!clr_n_s && (ld_rise || shift_en) |=>
      shreg_r == dac_r)
    else $error("clear did not override serial activity");

endmodule

`default_nettype wire

// file: dv/sdli_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdli_host_model (
  output logic select_n, // select, active low
  output logic shift_clock, // link clock, parked high
  output logic serial_in, // data to the device
  output logic load_strobe, // load, rising edge acts
  output logic async_clear_n, // clear, active low
  output logic clear_level_select // clear code choice
);
  // idle levels: deselected, clock high, no load, no clear
  initial
  begin
    {select_n, shift_clock, serial_in, load_strobe} = 4'hC;
    {async_clear_n, clear_level_select} = 2'h2;
  end
  // n bits msb first; data set while clock low, clock left high
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = 15; i > 15 - n; i--)
    begin
      shift_clock = 1'b0;
      serial_in = w[i];
      #100;
      shift_clock = 1'b1;
      #100;
    end
  endtask
  // select only moves while the clock is high
  task automatic sel(input logic b);
    select_n = b;
    #100;
  endtask
  // one load pulse; t_clear also calls it during a clear, before any word is shifted in
  task automatic load();
    load_strobe = 1'b1;
    #100;
    load_strobe = 1'b0;
    #100;
  endtask
  // clear level stays low until unclear
  task automatic clear(input logic lvl);
    clear_level_select = lvl;
    async_clear_n = 1'b0;
    #100;
  endtask
  task automatic unclear();
    async_clear_n = 1'b1;
    #100;
  endtask
  // deliberate misuse: deselect while the clock is low
  task automatic extra(input logic b);
    shift_clock = 1'b0;
    serial_in = b;
    #100;
    select_n = 1'b1;
    #100;
    shift_clock = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// file: dv/sdli_serial_dac_load_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sdli_serial_dac_load_tb;
  logic mclk, srst, select_n, shift_clock, serial_in, load_strobe;
  logic async_clear_n, clear_level_select, serial_out, serial_out_oe;
  sdli_pkg::sdli_code_t input_code, dac_code;
  int mismatches, checked;
  sdli_serial_dac_load sdli_serial_dac_load_i (.mclk(mclk), .srst(srst),
    .select_n(select_n), .shift_clock(shift_clock), .serial_in(serial_in),
    .load_strobe(load_strobe), .async_clear_n(async_clear_n),
    .clear_level_select(clear_level_select), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .input_code(input_code), .dac_code(dac_code));
  sdli_host_model sdli_host_model_i (.select_n(select_n), .shift_clock(shift_clock),
    .serial_in(serial_in), .load_strobe(load_strobe), .async_clear_n(async_clear_n),
    .clear_level_select(clear_level_select));
  // 40 MHz block clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk16(input sdli_pkg::sdli_code_t got, input sdli_pkg::sdli_code_t exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // clear overrides load; level change follows at once
  task automatic t_clear();
    sdli_host_model_i.clear(1'b1);
    chk16(input_code, 16'h8000);
    chk16(dac_code, 16'h8000);
    sdli_host_model_i.clear(1'b0);
    sdli_host_model_i.load();
    chk16(dac_code, 16'h0000);
    sdli_host_model_i.sel(1'b0);
    sdli_host_model_i.shift(16'hFFFF, 4);
    chk16(input_code, 16'h0000);
    sdli_host_model_i.sel(1'b1);
    sdli_host_model_i.unclear();
    $display("t_clear done");
  endtask
  task automatic t_word();
    sdli_host_model_i.sel(1'b0);
    chk1(serial_out_oe, 1'b1);
    sdli_host_model_i.shift(16'hA5C3, 16);
    chk16(input_code, 16'hA5C3);
    chk1(serial_out, 1'b1);
    sdli_host_model_i.sel(1'b1);
    chk1(serial_out_oe, 1'b0);
    sdli_host_model_i.load();
    chk16(dac_code, 16'hA5C3);
    sdli_host_model_i.load();
    chk16(dac_code, 16'hA5C3);
    $display("t_word done");
  endtask
  // clocks while deselected between the bytes must do nothing
  task automatic t_byte();
    sdli_host_model_i.sel(1'b0);
    sdli_host_model_i.shift(16'h3C96, 8);
    sdli_host_model_i.sel(1'b1);
    sdli_host_model_i.shift(16'hFFFF, 4);
    chk16(input_code, 16'hC33C);
    sdli_host_model_i.sel(1'b0);
    sdli_host_model_i.shift(16'h9600, 8);
    chk16(input_code, 16'h3C96);
    sdli_host_model_i.sel(1'b1);
    $display("t_byte done");
  endtask
  // continuous words, load between them, then a bad deselect
  task automatic t_cont();
    sdli_host_model_i.sel(1'b0);
    sdli_host_model_i.shift(16'h0F0F, 16);
    sdli_host_model_i.load();
    chk16(dac_code, 16'h0F0F);
    sdli_host_model_i.shift(16'h1234, 16);
    sdli_host_model_i.extra(1'b1);
    chk16(input_code, 16'h2469);
    $display("t_cont done");
  endtask
  initial
  begin
    srst = 1'b1;
    repeat (20) @(negedge mclk);
    srst <= 1'b0;
    t_clear();
    t_word();
    t_byte();
    t_cont();
    tally_and_finish();
  end
  // the whole run needs about 17 us
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
